// >>> inc/srbc_pkg.sv
/*
 * constants and types for the system reset and brownout control block.
 * assumes a single 125 MHz system clock with a synchronous active-low reset.
 */
// Operation
// - external pin, watchdog, power-on and brownout requests merge into one chip reset
// - any request restarts wake timer; release waits pin, oscillator, count, flash init
// - on release the processor fetches address zero, showing the boot block vector
// - all processor and peripheral registers hold reset values before release
// - first-stage brownout raises an interrupt line to the vectored interrupt controller
// - that line is enabled in the controller and also readable as a status level
// - second-stage brownout forces chip reset to protect flash contents
// - brownout reset holds until power-on detector takes over, with no release gap
// - a software mapping selection puts boot rom, sram or external memory at zero
// - up to 68 edge interrupt inputs and four level external interrupt inputs
// - an enabled external interrupt wakes the processor from power-down
// - after wake, count 4 MHz oscillator cycles and block flash until expiry
`default_nettype none
package srbc_pkg;
	// interrupt input counts
	localparam int N_EDGE = 68;
	localparam int N_LVL = 4;
	// wake-up timer, in system clocks
	localparam int WAKE_CLKS = 2048;
	localparam int WAKE_W = 16;
	// flash start-up after power-down, counted in oscillator cycles
	localparam int FLASH_US = 100;
	localparam int IRC_KHZ = 4000;
	localparam int FLASH_IRC_TICKS = FLASH_US * IRC_KHZ / 1000;
	localparam int FLASH_W = 12;
	// release pipeline depth
	localparam int REL_STAGES = 2;
	// address where fetching starts after release
	localparam logic [31:0] VEC_BASE = 32'h0000_0000;
	// vector area mapping selections
	typedef enum logic [1:0] {
		MAP_BOOT = 2'h0,
		MAP_SRAM = 2'h1,
		MAP_EXT = 2'h2
	} srbc_map_t;
	localparam logic [1:0] MAP_BAD = 2'h3;
	// sequencer states
	typedef enum logic [2:0] {
		ST_HOLD = 3'h1,
		ST_WAIT = 3'h2,
		ST_RUN = 3'h4
	} srbc_state_t;
endpackage : srbc_pkg
`default_nettype wire

// >>> hw/srbc_sync.sv
/*
 * two flip-flop synchroniser for a vector of independent levels.
 * assumes each bit is a slow level; multi-bit words must not be passed through it.
 */
`timescale 1ns/10ps
`default_nettype none
module srbc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// levels in and out
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	// meta is read only by the second stage
	always_comb begin
		next_meta = i_d;
		next_q = meta;
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			meta <= '0;
			o_q <= '0;
		end else begin
			meta <= next_meta;
			o_q <= next_q;
		end
	end
endmodule : srbc_sync
`default_nettype wire

// >>> hw/srbc_top.sv
/*
 * reset sequencer, brownout response, vector mapping and external interrupt front end.
 * assumes pins arrive asynchronously; watchdog, flash and cpu strobes are on i_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module srbc_top #(
	parameter int WAKE_CYCLES = srbc_pkg::WAKE_CLKS
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// reset sources
	input wire logic i_ext_rst_n,
	input wire logic i_wdt_timeout,
	input wire logic i_por,
	input wire logic i_bod_reset,
	// brownout first stage
	input wire logic i_bod_warn,
	// oscillator, flash and power state
	input wire logic i_osc_ok,
	input wire logic i_irc_clk,
	input wire logic i_flash_init_done,
	input wire logic i_pd_mode,
	// vector mapping write from cpu
	input wire logic i_map_wr,
	input wire logic [1:0] i_map_sel,
	// external interrupt pins
	input wire logic [srbc_pkg::N_EDGE-1:0] i_edge_irq,
	input wire logic [srbc_pkg::N_LVL-1:0] i_lvl_irq,
	input wire logic [srbc_pkg::N_LVL-1:0] i_lvl_irq_en,
	// reset and boot outputs
	output logic o_rst_n,
	output logic [31:0] o_fetch_addr,
	output logic [1:0] o_vec_map,
	// brownout interrupt and status
	output logic o_bod_irq,
	output logic o_bod_status,
	// interrupt and wake outputs
	output logic [srbc_pkg::N_EDGE-1:0] o_edge_irq,
	output logic [srbc_pkg::N_LVL-1:0] o_lvl_irq,
	output logic o_wake,
	output logic o_flash_ready
);
	import srbc_pkg::*;

	localparam int SW = N_EDGE + N_LVL + 6;
	localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CYCLES - 1);
	localparam logic [FLASH_W-1:0] FLASH_LAST = FLASH_W'(FLASH_IRC_TICKS - 1);

	logic [SW-1:0] sync_d;
	logic [SW-1:0] sync_q;
	logic ext_req_s, por_s, bod_rst_s, warn_s, osc_s, irc_s;
	logic [N_EDGE-1:0] edge_s;
	logic [N_LVL-1:0] lvl_s;
	logic raw_any, req_s;

	// every pin crosses two flops before the sequencer sees it; the reset pins also drive raw_any directly
	assign sync_d = {~i_ext_rst_n, i_por, i_bod_reset, i_bod_warn, i_osc_ok, i_irc_clk,
		i_lvl_irq, i_edge_irq};
	srbc_sync #(.W(SW)) u_sync (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_d(sync_d),
		.o_q(sync_q)
	);
	assign {ext_req_s, por_s, bod_rst_s, warn_s, osc_s, irc_s, lvl_s, edge_s} = sync_q;

	// raw pins assert reset at once; synced copies steer the sequencer
	assign raw_any = ~i_ext_rst_n | i_por | i_bod_reset;
	assign req_s = ext_req_s | por_s | bod_rst_s | i_wdt_timeout;

	// reset sequencer state
	srbc_state_t state, next_state;
	logic [WAKE_W-1:0] wake_cnt, next_wake_cnt;
	logic [REL_STAGES-1:0] rel, next_rel;
	logic [31:0] next_fetch_addr;
	logic [1:0] next_vec_map;

	always_comb begin
		next_state = state;
		next_wake_cnt = wake_cnt;
		unique case (state)
			ST_HOLD: begin
				next_wake_cnt = '0;
				if (!req_s) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (req_s) begin
					next_state = ST_HOLD;
					next_wake_cnt = '0;
				end else if (wake_cnt != WAKE_LAST) begin
					next_wake_cnt = wake_cnt + WAKE_W'(1);
				end else if (osc_s && i_flash_init_done) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (req_s) begin
					next_state = ST_HOLD;
				end
			end
			default: begin
				next_state = ST_HOLD;
			end
		endcase
		// release walks two flops; any request clears it at once
		next_rel = req_s ? '0 : {rel[REL_STAGES-2:0], state == ST_RUN};
		// fetch address and mapping go back to boot while reset is held
		next_fetch_addr = VEC_BASE;
		next_vec_map = o_vec_map;
		if (state != ST_RUN) begin
			next_vec_map = MAP_BOOT;
		end else if (i_map_wr && i_map_sel != MAP_BAD) begin
			next_vec_map = i_map_sel;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			state <= ST_HOLD;
			wake_cnt <= '0;
			rel <= '0;
			o_fetch_addr <= VEC_BASE;
			o_vec_map <= MAP_BOOT;
		end else begin
			state <= next_state;
			wake_cnt <= next_wake_cnt;
			rel <= next_rel;
			o_fetch_addr <= next_fetch_addr;
			o_vec_map <= next_vec_map;
		end
	end

	// one output resets core and peripherals together, so nothing leaves reset early
	assign o_rst_n = rel[REL_STAGES-1] & ~raw_any & i_nrst;

	// brownout warning and interrupt front end
	logic [N_EDGE-1:0] edge_d, next_edge_d, next_edge_irq;
	logic [N_LVL-1:0] next_lvl_irq;
	logic next_bod, next_wake;

	always_comb begin
		next_bod = warn_s;
		next_edge_d = edge_s;
		next_edge_irq = edge_s & ~edge_d;
		next_lvl_irq = lvl_s;
		next_wake = i_pd_mode && ((lvl_s & i_lvl_irq_en) != '0);
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_bod_irq <= 1'b0;
			o_bod_status <= 1'b0;
			edge_d <= '0;
			o_edge_irq <= '0;
			o_lvl_irq <= '0;
			o_wake <= 1'b0;
		end else begin
			o_bod_irq <= next_bod;
			o_bod_status <= next_bod;
			edge_d <= next_edge_d;
			o_edge_irq <= next_edge_irq;
			o_lvl_irq <= next_lvl_irq;
			o_wake <= next_wake;
		end
	end

	// flash start-up timer after a power-down wake, ticked by oscillator edges
	logic irc_d, next_irc_d, flash_busy, next_flash_busy;
	logic [FLASH_W-1:0] flash_cnt, next_flash_cnt;
	logic next_flash_ready;

	always_comb begin
		next_irc_d = irc_s;
		next_flash_busy = flash_busy;
		next_flash_cnt = flash_cnt;
		if (o_wake) begin
			next_flash_busy = 1'b1;
			next_flash_cnt = '0;
		end else if (flash_busy && irc_s && !irc_d) begin
			if (flash_cnt == FLASH_LAST) begin
				next_flash_busy = 1'b0;
			end else begin
				next_flash_cnt = flash_cnt + FLASH_W'(1);
			end
		end
		// the wake pulse blocks flash in the same edge that arms the timer;
		// the registered release is used so no raw pin reaches this flop
		next_flash_ready = !next_flash_busy && i_flash_init_done && rel[REL_STAGES-1];
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			irc_d <= 1'b0;
			flash_busy <= 1'b0;
			flash_cnt <= '0;
			o_flash_ready <= 1'b0;
		end else begin
			irc_d <= next_irc_d;
			flash_busy <= next_flash_busy;
			flash_cnt <= next_flash_cnt;
			o_flash_ready <= next_flash_ready;
		end
	end

	// checks on the outputs against their causes
	property p_merge;
		@(posedge i_clk) disable iff (!i_nrst)
		(~i_ext_rst_n | i_por | i_bod_reset) |-> !o_rst_n;
	endproperty
	a_merge: assert property (p_merge) else $error("reset request did not assert reset");

	property p_release_cond;
		@(posedge i_clk) disable iff (!i_nrst)
		$rose(o_rst_n) |-> $past(wake_cnt, 3) == WAKE_LAST && $past(osc_s, 3)
			&& $past(i_flash_init_done, 3);
	endproperty
	a_release_cond: assert property (p_release_cond) else $error("release before wake done");

	property p_boot_vec;
		@(posedge i_clk) disable iff (!i_nrst)
		$rose(o_rst_n) |-> o_fetch_addr == VEC_BASE && o_vec_map == MAP_BOOT;
	endproperty
	a_boot_vec: assert property (p_boot_vec) else $error("release without boot vector at zero");

	property p_held_long;
		@(posedge i_clk) disable iff (!i_nrst)
		$rose(req_s) |=> !o_rst_n [*3];
	endproperty
	a_held_long: assert property (p_held_long) else $error("reset too short for register init");

	property p_bod_irq;
		@(posedge i_clk) disable iff (!i_nrst)
		$rose(warn_s) |=> o_bod_irq;
	endproperty
	a_bod_irq: assert property (p_bod_irq) else $error("brownout warning not raised");

	property p_bod_status;
		@(posedge i_clk) disable iff (!i_nrst)
		o_bod_status == o_bod_irq;
	endproperty
	a_bod_status: assert property (p_bod_status) else $error("brownout status differs from line");

	property p_bod_reset;
		@(posedge i_clk) disable iff (!i_nrst)
		bod_rst_s |-> !o_rst_n ##1 (state != ST_RUN);
	endproperty
	a_bod_reset: assert property (p_bod_reset) else $error("brownout did not force reset");

	property p_handover;
		@(posedge i_clk) disable iff (!i_nrst)
		($fell(i_bod_reset) && i_por) |-> !o_rst_n [*2];
	endproperty
	a_handover: assert property (p_handover) else $error("reset gap at power-on handover");

	property p_map_wr;
		@(posedge i_clk) disable iff (!i_nrst)
		(state == ST_RUN && next_state == ST_RUN && i_map_wr && i_map_sel != MAP_BAD)
			|=> o_vec_map == $past(i_map_sel);
	endproperty
	a_map_wr: assert property (p_map_wr) else $error("mapping selection not taken");

	property p_wake;
		@(posedge i_clk) disable iff (!i_nrst)
		(i_pd_mode && (lvl_s & i_lvl_irq_en) != '0) |=> o_wake ##1 !o_flash_ready;
	endproperty
	a_wake: assert property (p_wake) else $error("enabled interrupt did not wake");

	property p_sync_release;
		@(posedge i_clk) disable iff (!i_nrst)
		$rose(o_rst_n) |-> $past(state == ST_RUN, 2);
	endproperty
	a_sync_release: assert property (p_sync_release) else $error("release not two flops late");
endmodule : srbc_top
`default_nettype wire

// >>> verif/srbc_core_model.sv
/*
 * behavioural model of the processor core and vectored interrupt controller.
 * assumes the block's outputs are on the same clock as this model.
 */
`timescale 1ns/10ps
`default_nettype none
module srbc_core_model (
	// clock and block outputs
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_bod_irq,
	input wire logic [31:0] i_fetch_addr,
	// controller enable for the brownout line
	input wire logic i_bod_en,
	// what the core sees
	output logic o_cpu_irq,
	output logic [31:0] o_first_fetch
);
	logic rst_q;
	// the line interrupts the core only when enabled in the controller
	assign o_cpu_irq = i_bod_irq & i_bod_en;
	// first fetch is latched as reset lifts; all ones while held, so stale zeros cannot pass
	always_ff @(posedge i_clk) begin
		rst_q <= i_rst_n;
		if (!i_rst_n) begin
			o_first_fetch <= 32'hFFFF_FFFF;
		end else if (!rst_q) begin
			o_first_fetch <= i_fetch_addr;
		end
	end
endmodule : srbc_core_model
`default_nettype wire

// >>> verif/srbc_tb_top.sv
/*
 * self-checking bench for the reset and brownout block with a core model.
 * assumes a shortened wake count and an oscillator divided down from i_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module srbc_tb_top;
	import srbc_pkg::*;
	localparam int WK = 8;
	typedef struct packed {logic [3:0] src; logic [1:0] sel; logic [1:0] map;} srbc_row_t;
	// one row per reset source, each followed by a mapping write
	srbc_row_t rows [4] = '{'{4'h1, 2'h1, 2'h1}, '{4'h2, 2'h2, 2'h2},
		'{4'h4, 2'h3, 2'h0}, '{4'h8, 2'h0, 2'h0}};
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic ext_n = 1'b1, wdt = 1'b0, por = 1'b0, bodr = 1'b0, warn = 1'b0, watch = 1'b0;
	logic osc = 1'b1, fdone = 1'b1, pd = 1'b0, mwr = 1'b0, bod_en = 1'b0;
	logic [1:0] msel = 2'h0;
	logic [1:0] idiv = 2'h0;
	logic [N_EDGE-1:0] eirq = '0;
	logic [N_LVL-1:0] lirq = 4'h0;
	logic [N_LVL-1:0] len = 4'h0;
	logic rst_n, irq, stat, wake, fready, cpu_irq;
	logic [31:0] faddr, first;
	logic [1:0] vmap;
	logic [N_EDGE-1:0] eout;
	logic [N_LVL-1:0] lout;
	int n_errors = 0;
	int total_checks = 0;
	int n;
	always #4 i_clk = ~i_clk;
	// oscillator at a quarter of the clock keeps the flash count short
	always @(posedge i_clk) idiv <= idiv + 2'h1;
	srbc_top #(.WAKE_CYCLES(WK)) srbc_top_inst (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_ext_rst_n(ext_n), .i_wdt_timeout(wdt), .i_por(por), .i_bod_reset(bodr),
		.i_bod_warn(warn), .i_osc_ok(osc), .i_irc_clk(idiv[1]), .i_flash_init_done(fdone),
		.i_pd_mode(pd), .i_map_wr(mwr), .i_map_sel(msel), .i_edge_irq(eirq),
		.i_lvl_irq(lirq), .i_lvl_irq_en(len), .o_rst_n(rst_n), .o_fetch_addr(faddr),
		.o_vec_map(vmap), .o_bod_irq(irq), .o_bod_status(stat), .o_edge_irq(eout),
		.o_lvl_irq(lout), .o_wake(wake), .o_flash_ready(fready));
	srbc_core_model srbc_core_model_inst (.i_clk(i_clk), .i_rst_n(rst_n), .i_bod_irq(irq),
		.i_fetch_addr(faddr), .i_bod_en(bod_en), .o_cpu_irq(cpu_irq), .o_first_fetch(first));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic finish_test();
		if (n_errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test
	task automatic step(input int k);
		repeat (k) @(posedge i_clk);
	endtask : step
	// bounded wait for the chip to leave reset; n holds the cycles taken
	task automatic wait_run();
		n = 0;
		while (rst_n !== 1'b1 && n < 200) begin
			@(negedge i_clk);
			n++;
		end
		if (n >= 200) begin
			n_errors++;
			finish_test();
		end
	endtask : wait_run
	// raise the sources in s for k+1 cycles, bit 0 is the pin, then drop them
	task automatic req(input logic [3:0] s, input int k);
		@(posedge i_clk);
		ext_n <= ~s[0];
		wdt <= s[1];
		por <= s[2];
		bodr <= s[3];
		step(k);
		@(negedge i_clk);
		chk(rst_n, 1'b0);
		@(posedge i_clk);
		ext_n <= 1'b1;
		wdt <= 1'b0;
		por <= 1'b0;
		bodr <= 1'b0;
	endtask : req
	// reset must stay low for every cycle of the brownout to power-on handover
	always @(negedge i_clk) begin
		if (watch) begin
			chk(rst_n, 1'b0);
		end
	end
	initial begin
		step(20000);
		n_errors++;
		finish_test();
	end
	initial begin
		step(12);
		i_nrst <= 1'b1;
		wait_run();
		foreach (rows[i]) begin
			req(rows[i].src, 4);
			wait_run();
			chk(n > WK, 1'b1);
			step(2);
			@(negedge i_clk);
			chk(first, 32'h0);
			chk(vmap, 2'h0);
			@(posedge i_clk);
			mwr <= 1'b1;
			msel <= rows[i].sel;
			@(posedge i_clk);
			mwr <= 1'b0;
			@(negedge i_clk);
			chk(vmap, rows[i].map);
		end
		// oscillator and flash init each gate the release on their own
		@(posedge i_clk);
		osc <= 1'b0;
		req(4'h4, 4);
		step(30);
		@(negedge i_clk);
		chk(rst_n, 1'b0);
		@(posedge i_clk);
		osc <= 1'b1;
		fdone <= 1'b0;
		step(30);
		@(negedge i_clk);
		chk(rst_n, 1'b0);
		@(posedge i_clk);
		fdone <= 1'b1;
		wait_run();
		// second stage hands over to power-on without a gap
		@(posedge i_clk);
		bodr <= 1'b1;
		step(2);
		watch <= 1'b1;
		step(3);
		por <= 1'b1;
		step(3);
		bodr <= 1'b0;
		step(3);
		por <= 1'b0;
		watch <= 1'b0;
		wait_run();
		// first stage: line and status follow, enable gates the core
		@(posedge i_clk);
		warn <= 1'b1;
		step(4);
		@(negedge i_clk);
		chk({irq, stat, cpu_irq}, 3'b110);
		@(posedge i_clk);
		bod_en <= 1'b1;
		@(negedge i_clk);
		chk(cpu_irq, 1'b1);
		@(posedge i_clk);
		warn <= 1'b0;
		step(4);
		@(negedge i_clk);
		chk({irq, stat}, 2'h0);
		// every edge input gives exactly one pulse, three edges after the pins rise
		@(posedge i_clk);
		eirq <= '1;
		n = 0;
		repeat (8) begin
			@(negedge i_clk);
			n += int'(eout === '1);
		end
		chk(n, 1);
		// level pin wakes only when enabled, and blocks flash meanwhile
		@(posedge i_clk);
		pd <= 1'b1;
		lirq <= 4'h8;
		step(5);
		@(negedge i_clk);
		chk({wake, lout}, {1'b0, 4'h8});
		@(posedge i_clk);
		len <= 4'h8;
		step(3);
		@(negedge i_clk);
		chk({wake, fready}, 2'b10);
		@(posedge i_clk);
		pd <= 1'b0;
		lirq <= 4'h0;
		// 400 oscillator rises at one per four clocks land 1598 to 1601 clocks from here
		step(1594);
		@(negedge i_clk);
		chk(fready, 1'b0);
		n = 0;
		while (fready !== 1'b1 && n < 200) begin
			@(negedge i_clk);
			n++;
		end
		chk(n < 12, 1'b1);
		finish_test();
	end
endmodule : srbc_tb_top
`default_nettype wire
